/* core/hdtc_core.sv */
// Functional notes
// - Manual code is two upper plus eight lower bits
// - Manual mode drives DAC with manual code directly
// - Detection enabled: low threshold trip enters holdover
// - Detection enabled: near-supply threshold trip enters holdover
// - Multiplier field decodes to 4, 64, 1024, 16384
// - Trip marks input invalid, raises switch event
// - Update period is multiplier times counter setting, a zero setting counting as one
// - Holdover outputs manual or last tracked code
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module hdtc_core
	import hdtc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire hdtc_bus_t bus_in,
	output logic [7:0] rd_data_out,
	input wire logic [9:0] tune_level_in,
	input wire logic ref_locked_in,
	input wire logic holdover_exit_in,
	output logic [9:0] dac_code_out,
	output logic holdover_out,
	output logic clk_switch_event_out,
	output logic track_update_out,
	output logic irq_out
);

	logic [7:0] man_upper_reg;
	logic [7:0] man_lower_reg;
	logic [5:0] low_trip_reg;
	logic [7:0] mult_high_reg;
	logic [7:0] cnt_reg;
	logic detect_reg;
	logic [2:0] mask_reg;
	logic [2:0] status_reg;
	logic [2:0] status_next;
	logic [9:0] tracked_reg;
	logic [9:0] tracked_next;
	logic [9:0] dac_reg;
	logic [9:0] dac_next;
	logic [14:0] pre_reg;
	logic [14:0] pre_next;
	logic [7:0] div_reg;
	logic [7:0] div_next;
	logic event_reg;
	logic update_reg;
	logic [7:0] rd_data_reg;
	hdtc_mode_t mode_reg;
	hdtc_mode_t mode_next;
	hdtc_cfg_t cfg;

	// Address decode
	wire wr_man_upper = bus_in.wr && (bus_in.addr == HDTC_OFS_MAN_UPPER);
	wire wr_man_lower = bus_in.wr && (bus_in.addr == HDTC_OFS_MAN_LOWER);
	wire wr_low_trip = bus_in.wr && (bus_in.addr == HDTC_OFS_LOW_TRIP);
	wire wr_mult_high = bus_in.wr && (bus_in.addr == HDTC_OFS_MULT_HIGH);
	wire wr_track_cnt = bus_in.wr && (bus_in.addr == HDTC_OFS_TRACK_CNT);
	wire wr_detect = bus_in.wr && (bus_in.addr == HDTC_OFS_DETECT);
	wire wr_status = bus_in.wr && (bus_in.addr == HDTC_OFS_STATUS);
	wire wr_mask = bus_in.wr && (bus_in.addr == HDTC_OFS_MASK);

	assign cfg.manual_sel = man_upper_reg[HDTC_SEL_BIT];
	assign cfg.force_hold = man_upper_reg[HDTC_FORCE_BIT];
	assign cfg.track_en = man_upper_reg[HDTC_TRACK_BIT];
	assign cfg.detect_en = detect_reg;
	assign cfg.mult = mult_high_reg[HDTC_MULT_LSB+1:HDTC_MULT_LSB];
	assign cfg.high_n = mult_high_reg[HDTC_TRIP_MSB:0];
	assign cfg.low_n = low_trip_reg;
	// Upper two bits above the full lower byte
	assign cfg.manual_dac_value = {man_upper_reg[HDTC_MAN_HI_MSB:0],
		man_lower_reg};
	assign cfg.cnt = cnt_reg;

	// Multiplier decode
	wire [14:0] mult_val = (cfg.mult == 2'd0) ? HDTC_MULT_0 :
		(cfg.mult == 2'd1) ? HDTC_MULT_1 :
		(cfg.mult == 2'd2) ? HDTC_MULT_2 : HDTC_MULT_3;

	// Rate divider: prescale by multiplier, then by counter setting
	wire pre_wrap = (pre_reg >= (mult_val - 15'h0001));
	wire [7:0] div_target = (cfg.cnt == 8'h00) ? 8'h00 :
		(cfg.cnt - 8'h01);
	wire track_update = pre_wrap && (div_reg >= div_target);
	assign pre_next = pre_wrap ? 15'h0000 : (pre_reg + 15'h0001);
	assign div_next = !pre_wrap ? div_reg :
		(track_update ? 8'h00 : (div_reg + 8'h01));

	// Tracking only while locked and not in holdover
	wire sample_en = track_update && cfg.track_en && ref_locked_in &&
		(mode_reg == HDTC_TRACK);
	assign tracked_next = sample_en ? tune_level_in : tracked_reg;

	// Trip compare on each fresh sample, six-bit scale
	wire [5:0] level_scale = tune_level_in[9:4];
	wire low_hit = sample_en && cfg.detect_en &&
		(level_scale <= cfg.low_n);
	wire high_hit = sample_en && cfg.detect_en &&
		(level_scale >= (HDTC_TRIP_TOP - cfg.high_n));
	wire switch_event = low_hit || high_hit;

	// Holdover mode machine
	always_comb
	begin
		mode_next = mode_reg;
		case (mode_reg)
			HDTC_TRACK:
			begin
				if (switch_event || cfg.force_hold)
					mode_next = HDTC_HOLD;
			end
			HDTC_HOLD:
			begin
				if (holdover_exit_in && !cfg.force_hold)
					mode_next = HDTC_TRACK;
			end
			default:
			begin
				mode_next = HDTC_TRACK;
			end
		endcase
	end

	wire hold_entry = (mode_reg == HDTC_TRACK) && (mode_next == HDTC_HOLD);

	// Manual code whenever selected, otherwise last tracked code
	assign dac_next = cfg.manual_sel ? cfg.manual_dac_value :
		tracked_next;

	// Sticky events; a new event beats a same-cycle clear
	wire [2:0] set_vec = {hold_entry, high_hit, low_hit};
	wire [2:0] clr_vec = wr_status ? bus_in.wdata[2:0] : 3'h0;
	assign status_next = (status_reg & ~clr_vec) | set_vec;

	// Read selection
	wire [7:0] rd_mux =
		(bus_in.addr == HDTC_OFS_MAN_UPPER) ? man_upper_reg :
		(bus_in.addr == HDTC_OFS_MAN_LOWER) ? man_lower_reg :
		(bus_in.addr == HDTC_OFS_LOW_TRIP) ? {2'b00, low_trip_reg} :
		(bus_in.addr == HDTC_OFS_MULT_HIGH) ? mult_high_reg :
		(bus_in.addr == HDTC_OFS_TRACK_CNT) ? cnt_reg :
		(bus_in.addr == HDTC_OFS_DETECT) ?
			{5'h00, detect_reg, 2'b00} :
		(bus_in.addr == HDTC_OFS_STATUS) ? {5'h00, status_reg} :
		(bus_in.addr == HDTC_OFS_MASK) ? {5'h00, mask_reg} :
		(bus_in.addr == HDTC_OFS_TRK_HI) ? {6'h00, tracked_reg[9:8]} :
		(bus_in.addr == HDTC_OFS_TRK_LO) ? tracked_reg[7:0] :
		(bus_in.addr == HDTC_OFS_MODE) ? {7'h00, mode_reg} :
		8'h00;

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			man_upper_reg <= HDTC_RST_MAN_UPPER;
			man_lower_reg <= HDTC_RST_MAN_LOWER;
			low_trip_reg <= HDTC_RST_LOW_TRIP;
			mult_high_reg <= HDTC_RST_MULT_HIGH;
		end
		else
		begin
			if (wr_man_upper)
				man_upper_reg <= bus_in.wdata;
			if (wr_man_lower)
				man_lower_reg <= bus_in.wdata;
			if (wr_low_trip)
				low_trip_reg <= bus_in.wdata[HDTC_TRIP_MSB:0];
			if (wr_mult_high)
				mult_high_reg <= bus_in.wdata;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cnt_reg <= HDTC_RST_TRACK_CNT;
			detect_reg <= HDTC_RST_DETECT;
			mask_reg <= HDTC_RST_MASK;
			status_reg <= 3'h0;
		end
		else
		begin
			if (wr_track_cnt)
				cnt_reg <= bus_in.wdata;
			if (wr_detect)
				detect_reg <= bus_in.wdata[HDTC_DETECT_BIT];
			if (wr_mask)
				mask_reg <= bus_in.wdata[2:0];
			status_reg <= status_next;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pre_reg <= 15'h0000;
			div_reg <= 8'h00;
			tracked_reg <= HDTC_RST_TRACKED;
			dac_reg <= HDTC_RST_TRACKED;
			mode_reg <= HDTC_TRACK;
		end
		else
		begin
			pre_reg <= pre_next;
			div_reg <= div_next;
			tracked_reg <= tracked_next;
			dac_reg <= dac_next;
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			event_reg <= 1'b0;
			update_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end
		else
		begin
			event_reg <= switch_event;
			update_reg <= sample_en;
			rd_data_reg <= bus_in.rd ? rd_mux : 8'h00;
		end
	end

	assign rd_data_out = rd_data_reg;
	assign dac_code_out = dac_reg;
	assign holdover_out = (mode_reg == HDTC_HOLD);
	assign clk_switch_event_out = event_reg;
	assign track_update_out = update_reg;
	assign irq_out = |(status_reg & mask_reg);

	// Helper: cycles between divider wraps, valid once settings stand
	logic [21:0] gap_reg;
	logic gap_valid_reg;
	wire [21:0] gap_expect = 22'(mult_val) *
		22'((cfg.cnt == 8'h00) ? 8'h01 : cfg.cnt);
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			gap_reg <= 22'h00_0000;
			gap_valid_reg <= 1'b0;
		end
		else
		begin
			gap_reg <= track_update ? 22'h00_0000 : (gap_reg + 22'h00_0001);
			if (wr_mult_high || wr_track_cnt)
				gap_valid_reg <= 1'b0;
			else if (track_update)
				gap_valid_reg <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_trip_seen;
		switch_event ##1 clk_switch_event_out;
	endsequence

	sequence s_hold_entered;
		holdover_out && status_reg[HDTC_ST_HOLD];
	endsequence

	// Lower byte written once, not rewritten on the next edge
	sequence s_lower_written;
		wr_man_lower ##1 !wr_man_lower;
	endsequence

	a_manual_concat: assert property (
		s_lower_written |->
		cfg.manual_dac_value[7:0] == $past(bus_in.wdata) ##1
		(dac_code_out[7:0] == $past(bus_in.wdata, 2) ||
		!$past(cfg.manual_sel)))
		else $error("manual code lower byte not applied");

	a_manual_upper: assert property (
		wr_man_upper |=>
		cfg.manual_dac_value[9:8] == $past(bus_in.wdata[HDTC_MAN_HI_MSB:0]))
		else $error("manual code upper bits not applied");

	a_manual_drive: assert property (
		cfg.manual_sel && $stable(cfg.manual_dac_value) |=>
		dac_code_out == $past(cfg.manual_dac_value))
		else $error("manual code not driven to DAC");

	a_low_trip: assert property (
		low_hit |=> status_reg[HDTC_ST_LOW] && clk_switch_event_out)
		else $error("low threshold trip not flagged");

	a_high_trip: assert property (
		high_hit |=> status_reg[HDTC_ST_HIGH] && clk_switch_event_out)
		else $error("high threshold trip not flagged");

	a_mult_spacing: assert property (
		track_update && gap_valid_reg && !wr_mult_high && !wr_track_cnt
		&& $stable(mult_high_reg) && $stable(cnt_reg) |->
		gap_reg == gap_expect - 22'h00_0001)
		else $error("tracking update spacing wrong");

	a_switch_hold: assert property (
		s_trip_seen |-> s_hold_entered)
		else $error("trip did not enter holdover");

	a_trip_enable: assert property (
		!cfg.detect_en |=> !clk_switch_event_out)
		else $error("switch event while detection off");

	a_update_rate: assert property (
		track_update_out |-> $past(track_update) ##1
		!track_update_out || (gap_expect == 22'h00_0001))
		else $error("tracked update not on divider wrap");

	a_hold_output: assert property (
		holdover_out && $past(holdover_out) && !$past(cfg.manual_sel)
		|-> dac_code_out == tracked_reg && $stable(tracked_reg))
		else $error("holdover does not hold tracked code");

	a_trip_on_update: assert property (
		clk_switch_event_out |->
		$past(sample_en) && tracked_reg == $past(tune_level_in))
		else $error("trip evaluated outside an update");

	a_status_set_wins: assert property (
		wr_status |=>
		(status_reg & $past(set_vec)) == $past(set_vec))
		else $error("event lost against clear");

	// Read data only in the cycle after a read strobe
	a_read_idle_zero: assert property (
		!$past(bus_in.rd) |-> rd_data_out == 8'h00)
		else $error("read data outside its cycle");

	// Force bit enters holdover and blocks the exit request
	a_force_holds: assert property (
		cfg.force_hold |=> holdover_out)
		else $error("forced holdover not held");

endmodule // hdtc_core
`default_nettype wire

/* pkg/hdtc_pkg.sv */
package hdtc_pkg;
	// Register byte offsets
	localparam logic [8:0] HDTC_OFS_MAN_UPPER = 9'h14b;
	localparam logic [8:0] HDTC_OFS_MAN_LOWER = 9'h14c;
	localparam logic [8:0] HDTC_OFS_LOW_TRIP = 9'h14d;
	localparam logic [8:0] HDTC_OFS_MULT_HIGH = 9'h14e;
	localparam logic [8:0] HDTC_OFS_TRACK_CNT = 9'h14f;
	localparam logic [8:0] HDTC_OFS_DETECT = 9'h150;
	localparam logic [8:0] HDTC_OFS_STATUS = 9'h153;
	localparam logic [8:0] HDTC_OFS_MASK = 9'h154;
	localparam logic [8:0] HDTC_OFS_TRK_HI = 9'h155;
	localparam logic [8:0] HDTC_OFS_TRK_LO = 9'h156;
	localparam logic [8:0] HDTC_OFS_MODE = 9'h157;
	// Reset values
	localparam logic [7:0] HDTC_RST_MAN_UPPER = 8'h16;
	localparam logic [7:0] HDTC_RST_MAN_LOWER = 8'h00;
	localparam logic [5:0] HDTC_RST_LOW_TRIP = 6'h00;
	localparam logic [7:0] HDTC_RST_MULT_HIGH = 8'h00;
	localparam logic [7:0] HDTC_RST_TRACK_CNT = 8'h7f;
	localparam logic HDTC_RST_DETECT = 1'b0;
	localparam logic [2:0] HDTC_RST_MASK = 3'h0;
	localparam logic [9:0] HDTC_RST_TRACKED = 10'h200;
	// Field positions
	localparam int HDTC_MAN_HI_MSB = 1;
	localparam int HDTC_SEL_BIT = 2;
	localparam int HDTC_FORCE_BIT = 3;
	localparam int HDTC_TRACK_BIT = 4;
	localparam int HDTC_DETECT_BIT = 2;
	localparam int HDTC_MULT_LSB = 6;
	localparam int HDTC_TRIP_MSB = 5;
	localparam int HDTC_ST_LOW = 0;
	localparam int HDTC_ST_HIGH = 1;
	localparam int HDTC_ST_HOLD = 2;
	// Tracking rate multiplier values, in phase detector cycles
	localparam logic [14:0] HDTC_MULT_0 = 15'h0004;
	localparam logic [14:0] HDTC_MULT_1 = 15'h0040;
	localparam logic [14:0] HDTC_MULT_2 = 15'h0400;
	localparam logic [14:0] HDTC_MULT_3 = 15'h4000;
	localparam logic [5:0] HDTC_TRIP_TOP = 6'h3f;

	typedef enum logic {
		HDTC_TRACK = 1'b0,
		HDTC_HOLD = 1'b1
	} hdtc_mode_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hdtc_bus_t;

	typedef struct packed {
		logic manual_sel;
		logic force_hold;
		logic track_en;
		logic detect_en;
		logic [1:0] mult;
		logic [5:0] high_n;
		logic [5:0] low_n;
		logic [9:0] manual_dac_value;
		logic [7:0] cnt;
	} hdtc_cfg_t;
endpackage

/* testbench/hdtc_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module hdtc_core_tb
	import hdtc_pkg::*;
;
	logic clk;
	logic nrst;
	logic ref_locked;
	logic hold_exit;
	logic rd_seen;
	logic hold;
	logic evt;
	logic upd;
	logic irq;
	logic [9:0] tune;
	logic [9:0] dac;
	logic [9:0] l;
	logic [7:0] rd_data;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000_0060;
	hdtc_bus_t bus;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	hdtc_core dut_u (
		.core_clk_in(clk),
		.nrst_in(nrst),
		.bus_in(bus),
		.rd_data_out(rd_data),
		.tune_level_in(tune),
		.ref_locked_in(ref_locked),
		.holdover_exit_in(hold_exit),
		.dac_code_out(dac),
		.holdover_out(hold),
		.clk_switch_event_out(evt),
		.track_update_out(upd),
		.irq_out(irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic final_report();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask

	task automatic xfer(input logic [8:0] a, input logic [7:0] d,
		input logic w);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		xfer(a, 8'h00, 1'b0);
	endtask

	// Returns at the edge that closes an update pulse cycle
	task automatic wait_upd(output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
		end
		while (upd !== 1'b1 && c < 20000);
	endtask

	// Read data monitor: compares the cycle after each read strobe
	always @(posedge clk)
	begin
		if (rd_seen === 1'b1)
			chk(rd_data, exp_q.pop_front());
		rd_seen <= bus.rd;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			fails++;
			final_report();
		end
	end

	initial
	begin
		nrst = 1'b0;
		ref_locked = 1'b0;
		hold_exit = 1'b0;
		tune = 10'h180;
		bus = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		chk(dac, HDTC_RST_TRACKED);
		rd(HDTC_OFS_MAN_UPPER, HDTC_RST_MAN_UPPER);
		rd(HDTC_OFS_MAN_LOWER, HDTC_RST_MAN_LOWER);
		rd(HDTC_OFS_LOW_TRIP, 8'h00);
		rd(HDTC_OFS_MULT_HIGH, HDTC_RST_MULT_HIGH);
		rd(HDTC_OFS_TRACK_CNT, HDTC_RST_TRACK_CNT);
		rd(9'h151, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			l = (i == 1) ? 10'h3ff : 10'(rnd());
			xfer(HDTC_OFS_MAN_LOWER, l[7:0], 1'b1);
			xfer(HDTC_OFS_MAN_UPPER, {6'h05, l[9:8]}, 1'b1);
			repeat (2) @(posedge clk);
			chk(dac, l);
			rd(HDTC_OFS_MAN_LOWER, l[7:0]);
		end
		xfer(HDTC_OFS_TRACK_CNT, 8'h01, 1'b1);
		xfer(HDTC_OFS_MAN_UPPER, 8'h10, 1'b1);
		ref_locked <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			xfer(HDTC_OFS_MULT_HIGH, {m[1:0], 6'h00}, 1'b1);
			wait_upd(n);
			l = 10'(rnd());
			tune <= l;
			wait_upd(n);
			chk(16'(n), 16'(4 << (4 * m)));
			chk(dac, l);
		end
		tune <= 10'h180;
		xfer(HDTC_OFS_MASK, 8'h01, 1'b1);
		xfer(HDTC_OFS_LOW_TRIP, 8'h0a, 1'b1);
		xfer(HDTC_OFS_MULT_HIGH, 8'h05, 1'b1);
		xfer(HDTC_OFS_DETECT, 8'h04, 1'b1);
		// Boundary low trip, just above it, boundary high trip
		for (int k = 0; k < 3; k++)
		begin
			l = {(k == 0) ? 6'h0a : (k == 1) ? 6'h0b : 6'h3a, 4'(rnd())};
			// Leave holdover on a safe level, then align to an update
			tune <= 10'h180;
			hold_exit <= 1'b1;
			@(posedge clk);
			hold_exit <= 1'b0;
			wait_upd(n);
			tune <= l;
			wait_upd(n);
			chk(evt, k != 1);
			chk(hold, k != 1);
			chk(irq, k == 0);
			tune <= l ^ 10'h3ff;
			repeat (6) @(posedge clk);
			chk(dac, (k != 1) ? l : (l ^ 10'h3ff));
			rd(HDTC_OFS_STATUS, (k == 1) ? 8'h00 : (k == 0) ? 8'h05 : 8'h06);
			xfer(HDTC_OFS_STATUS, 8'h07, 1'b1);
			@(posedge clk);
			chk(irq, 1'b0);
		end
		rd(HDTC_OFS_TRK_HI, {6'h00, l[9:8]});
		rd(HDTC_OFS_TRK_LO, l[7:0]);
		rd(HDTC_OFS_MODE, 8'h01);
		rd(HDTC_OFS_DETECT, 8'h04);
		rd(HDTC_OFS_MASK, 8'h01);
		// Forced holdover with manual select, exit refused
		xfer(HDTC_OFS_MAN_UPPER, 8'h1f, 1'b1);
		hold_exit <= 1'b1;
		ref_locked <= 1'b0;
		repeat (3) @(posedge clk);
		chk(hold, 1'b1);
		chk(dac, 10'h3ff);
		// Force off: exit, but no sample while unlocked
		xfer(HDTC_OFS_MAN_UPPER, 8'h10, 1'b1);
		repeat (12) @(posedge clk);
		chk(hold, 1'b0);
		chk(dac, l);
		chk(16'(exp_q.size()), 16'h0000);
		final_report();
	end
endmodule // hdtc_core_tb
`default_nettype wire
